// [common/fcd_pkg.sv]
// Constants and carrier types for the flash command controller.
// Assumes a 20 MHz reference clock and a flash bus driven with pins active low.
package fcd_pkg;

  localparam int unsigned CLK_MHZ = 20;
  // Least strobe low time and least recovery high time, in ns.
  localparam int unsigned STROBE_LOW_NS = 100;
  localparam int unsigned STROBE_HIGH_NS = 50;
  localparam int unsigned STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] LOW_CYC = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] HIGH_CYC = 4'(STROBE_HIGH_CYC);

  // Command codes.
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_WRITE = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT = 8'h10;
  localparam logic [7:0] CMD_MULTI_WRITE = 8'hE8;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET = 8'h01;
  localparam logic [7:0] CMD_RB_CONFIG = 8'hB8;
  localparam logic [7:0] RB_LEVEL = 8'h00;
  localparam logic [7:0] RB_PULSE_BOTH = 8'h03;

  // Controller register offsets (word index on the local port).
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;

  // Operation codes written to the command register.
  typedef enum logic [3:0] {
    OP_WRITE_CYCLE, OP_READ_CYCLE
  } fcd_op_type;

  typedef struct packed {
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic rp_b;
    logic wp;
  } fcd_ctl_type;

  localparam fcd_ctl_type CTL_IDLE = '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, rp_b: 1'b0, wp: 1'b0};

endpackage

// [src/fcd_host.sv]
// Host controller that issues bus cycles and command sequences to a parallel flash.
// Assumes software on a one-cycle local port and flash pins with no synchroniser beyond the
// three-stage capture of the ready/busy line and returning data.
//
// Overview of operation
// - One write of FFH selects array read; reads stay array until changed.
// - Write 90H then read identifier addresses for identifier values.
// - Write 98H then reads return query values at the query offset.
// - Write 70H then one read at any address returns status.
// - Block erase is 20H then D0H, both inside the block.
// - Chip erase is 30H then D0H at any address.
// - Multi write is E8H, count minus one, N pairs, then D0H.
// - One write of B0H requests suspend of erase or write.
// - One write of D0H confirms or resumes.
// - Lock set is 60H then 01H in the block, write protect high.
// - Lock clear is 60H then D0H, write protect high, clears all.
// - Erase or write to locked blocks needs write protect high.
// - B8H then mode 00H to 03H configures the ready/busy output.
// - Output enable and write enable are never low together.
// - Only defined command codes are ever written; the host passes any byte after 60H or B8H unchecked.
// - 50H clears sticky errors; ignored while busy or suspended.
module fcd_host #(
  parameter int unsigned ADDR_W = 21,
  parameter int unsigned DATA_W = 16
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Local register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Flash pins.
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic flash_ce_b_o,
  output logic flash_oe_b_o,
  output logic flash_we_b_o,
  output logic flash_rp_b_o,
  output logic flash_wp_o,
  input wire logic ready_busy_output_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input capture.

  logic [2:0] rb_sync_r, rb_sync_nxt;
  logic rb_level_r, rb_level_nxt;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
  logic [DATA_W-1:0] dq_s1_nxt, dq_s2_nxt, dq_s3_nxt;

  always_comb begin
    rb_sync_nxt = {rb_sync_r[1:0], ready_busy_output_i};
    rb_level_nxt = rb_level_r;
    // A change counts only once the second and third stages agree.
    if (rb_sync_r[1] == rb_sync_r[2]) begin
      rb_level_nxt = rb_sync_r[2];
    end
    dq_s1_nxt = flash_dq_i;
    dq_s2_nxt = dq_s1_r;
    dq_s3_nxt = dq_s2_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rb_sync_r <= 3'h7;
      rb_level_r <= 1'b1;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dq_s3_r <= '0;
    end else begin
      rb_sync_r <= rb_sync_nxt;
      rb_level_r <= rb_level_nxt;
      dq_s1_r <= dq_s1_nxt;
      dq_s2_r <= dq_s2_nxt;
      dq_s3_r <= dq_s3_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer.

  typedef enum {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_SAMPLE, ST_RECOVER
  } fcd_state_type;

  fcd_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic is_read_r, is_read_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic dq_oe_r, dq_oe_nxt;
  fcd_pkg::fcd_ctl_type ctl_r, ctl_nxt;
  logic err_r, err_nxt;
  logic done_r, done_nxt;
  logic rb_level_mode_r, rb_level_mode_nxt;
  logic [7:0] prev_cmd_r, prev_cmd_nxt;
  logic [31:0] rdata_o_r, rdata_o_nxt;
  logic cmd_ok;
  logic [7:0] wbyte;

  // Codes accepted as the first cycle of a command, or as a known second cycle.
  always_comb begin
    wbyte = wdata_r[7:0];
    cmd_ok = 1'b0;
    if (wbyte == fcd_pkg::CMD_READ_ARRAY || wbyte == fcd_pkg::CMD_READ_IDENT
        || wbyte == fcd_pkg::CMD_QUERY || wbyte == fcd_pkg::CMD_READ_STATUS
        || wbyte == fcd_pkg::CMD_CLEAR_STATUS || wbyte == fcd_pkg::CMD_BLOCK_ERASE
        || wbyte == fcd_pkg::CMD_CHIP_ERASE || wbyte == fcd_pkg::CMD_WRITE
        || wbyte == fcd_pkg::CMD_WRITE_ALT || wbyte == fcd_pkg::CMD_MULTI_WRITE
        || wbyte == fcd_pkg::CMD_SUSPEND || wbyte == fcd_pkg::CMD_CONFIRM
        || wbyte == fcd_pkg::CMD_LOCK_SETUP || wbyte == fcd_pkg::CMD_RB_CONFIG) begin
      cmd_ok = 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    is_read_nxt = is_read_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    dq_oe_nxt = dq_oe_r;
    ctl_nxt = ctl_r;
    err_nxt = err_r;
    done_nxt = done_r;
    rb_level_mode_nxt = rb_level_mode_r;
    prev_cmd_nxt = prev_cmd_r;
    rdata_o_nxt = 32'h0000_0000;
    if (reg_wr_i && state_r == ST_IDLE) begin
      if (reg_addr_i == fcd_pkg::REG_ADDR) begin
        addr_nxt = reg_wdata_i[ADDR_W-1:0];
      end else if (reg_addr_i == fcd_pkg::REG_DATA) begin
        wdata_nxt = reg_wdata_i[DATA_W-1:0];
      end else if (reg_addr_i == fcd_pkg::REG_CTRL) begin
        // Entering power-down returns the flash to array read.
        ctl_nxt.rp_b = reg_wdata_i[0];
        ctl_nxt.wp = reg_wdata_i[1];
        if (!reg_wdata_i[0]) begin
          prev_cmd_nxt = fcd_pkg::CMD_READ_ARRAY;
        end
      end else if (reg_addr_i == fcd_pkg::REG_CMD) begin
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        is_read_nxt = (reg_wdata_i[3:0] == 4'(fcd_pkg::OP_READ_CYCLE));
        state_nxt = ST_SETUP;
        cnt_nxt = 4'h0;
      end
    end
    case (state_r)
      ST_IDLE: begin
      end
      ST_SETUP: begin
        // Commands follow array-read, mode and setup codes; data cycles are free after setup codes.
        if (!is_read_r && !ctl_r.rp_b) begin
          err_nxt = 1'b1;
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end else if (!is_read_r && !cmd_ok && !(prev_cmd_r == fcd_pkg::CMD_WRITE
                     || prev_cmd_r == fcd_pkg::CMD_WRITE_ALT || prev_cmd_r == fcd_pkg::CMD_MULTI_WRITE
                     || prev_cmd_r == fcd_pkg::CMD_LOCK_SETUP || prev_cmd_r == fcd_pkg::CMD_RB_CONFIG)) begin
          err_nxt = 1'b1;
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end else begin
          ctl_nxt.ce_b = 1'b0;
          dq_oe_nxt = !is_read_r;
          state_nxt = ST_STROBE;
          cnt_nxt = fcd_pkg::LOW_CYC;
          // Only one of the two strobes is ever lowered.
          if (is_read_r) begin
            ctl_nxt.oe_b = 1'b0;
          end else begin
            ctl_nxt.we_b = 1'b0;
          end
        end
      end
      ST_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = is_read_r ? ST_SAMPLE : ST_RECOVER;
          if (!is_read_r) begin
            // Write strobe rises with address and data still driven.
            ctl_nxt.we_b = 1'b1;
            ctl_nxt.ce_b = 1'b1;
            cnt_nxt = fcd_pkg::HIGH_CYC;
            if (prev_cmd_r == fcd_pkg::CMD_RB_CONFIG) begin
              rb_level_mode_nxt = (wbyte == fcd_pkg::RB_LEVEL);
            end
            // Remember the last code so the next cycle may carry payload.
            if (prev_cmd_r == fcd_pkg::CMD_WRITE || prev_cmd_r == fcd_pkg::CMD_WRITE_ALT
                || prev_cmd_r == fcd_pkg::CMD_LOCK_SETUP || prev_cmd_r == fcd_pkg::CMD_RB_CONFIG) begin
              prev_cmd_nxt = 8'h00;
            end else if (prev_cmd_r != fcd_pkg::CMD_MULTI_WRITE || wbyte == fcd_pkg::CMD_CONFIRM) begin
              // FFH, 90H, 98H, 70H, 50H, B0H, D0H, 20H, 30H go out as single cycles.
              prev_cmd_nxt = wbyte;
            end
          end
        end
      end
      ST_SAMPLE: begin
        // Data passes three capture stages before it is taken.
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'h3) begin
          rdata_nxt = dq_s3_r;
          ctl_nxt.oe_b = 1'b1;
          ctl_nxt.ce_b = 1'b1;
          cnt_nxt = fcd_pkg::HIGH_CYC;
          state_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Strobes stay high here so a status re-read latches fresh contents.
        dq_oe_nxt = 1'b0;
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r <= 4'h1) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (reg_rd_i) begin
      if (reg_addr_i == fcd_pkg::REG_STATUS) begin
        // Busy reads from the pin only in level mode.
        rdata_o_nxt = {27'h0, rb_level_mode_r && !rb_level_r, rb_level_mode_r, err_r, done_r,
                       state_r != ST_IDLE};
      end else if (reg_addr_i == fcd_pkg::REG_RDATA) begin
        rdata_o_nxt = 32'(rdata_r);
      end else if (reg_addr_i == fcd_pkg::REG_ADDR) begin
        rdata_o_nxt = 32'(addr_r);
      end else if (reg_addr_i == fcd_pkg::REG_DATA) begin
        rdata_o_nxt = 32'(wdata_r);
      end else if (reg_addr_i == fcd_pkg::REG_CTRL) begin
        rdata_o_nxt = {22'h0, prev_cmd_r, ctl_r.wp, ctl_r.rp_b};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      is_read_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      dq_oe_r <= 1'b0;
      ctl_r <= fcd_pkg::CTL_IDLE;
      err_r <= 1'b0;
      done_r <= 1'b0;
      rb_level_mode_r <= 1'b1;
      prev_cmd_r <= fcd_pkg::CMD_READ_ARRAY;
      rdata_o_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      is_read_r <= is_read_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      dq_oe_r <= dq_oe_nxt;
      ctl_r <= ctl_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      rb_level_mode_r <= rb_level_mode_nxt;
      prev_cmd_r <= prev_cmd_nxt;
      rdata_o_r <= rdata_o_nxt;
    end
  end

  assign reg_rdata_o = rdata_o_r;
  assign flash_addr_o = addr_r;
  assign flash_dq_o = wdata_r;
  assign flash_dq_oe_o = dq_oe_r;
  assign flash_ce_b_o = ctl_r.ce_b;
  assign flash_oe_b_o = ctl_r.oe_b;
  assign flash_we_b_o = ctl_r.we_b;
  assign flash_rp_b_o = ctl_r.rp_b;
  assign flash_wp_o = ctl_r.wp;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_no_both_low;
    @(posedge ref_clk_i) disable iff (!rst_b_i) !(!ctl_r.oe_b && !ctl_r.we_b);
  endproperty
  a_no_both_low: assert property (p_no_both_low) else $error("oe and we low together");

  property p_we_data_held;
    @(posedge ref_clk_i) disable iff (!rst_b_i) $rose(ctl_r.we_b) |-> dq_oe_r && $stable(wdata_r) && $stable(addr_r);
  endproperty
  a_we_data_held: assert property (p_we_data_held) else $error("data not held at write strobe rise");

  property p_oe_recover;
    @(posedge ref_clk_i) disable iff (!rst_b_i) $rose(ctl_r.oe_b) |-> ctl_r.oe_b [*2];
  endproperty
  a_oe_recover: assert property (p_oe_recover) else $error("read strobe not high between reads");

  property p_no_write_in_powerdown;
    @(posedge ref_clk_i) disable iff (!rst_b_i) $fell(ctl_r.we_b) |-> ctl_r.rp_b;
  endproperty
  a_no_write_in_powerdown: assert property (p_no_write_in_powerdown) else $error("write in power-down");

  // The write strobe stays low for the programmed low time before it rises.
  property p_we_low_width;
    @(posedge ref_clk_i) disable iff (!rst_b_i) $fell(ctl_r.we_b) |-> !ctl_r.we_b [*2] ##1 ctl_r.we_b;
  endproperty
  a_we_low_width: assert property (p_we_low_width) else $error("write strobe width wrong");

  // The host must never drive the data lines while the flash drives them.
  property p_no_drive_on_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i) !ctl_r.oe_b |-> !dq_oe_r;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("data driven during read");

endmodule

// [verification/fcd_flash_model.sv]
// Behavioural model of the parallel flash that the command controller drives.
// Assumes active-low strobes from the host and a board pull-up on the ready/busy line.
module fcd_flash_model #(
  parameter int unsigned ADDR_W = 21,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned BUSY_NS = 5000,
  // Arbitrary identity values of our own making.
  parameter logic [15:0] MFR_CODE = 16'h00A1,
  parameter logic [15:0] DEV_CODE = 16'h00B2
) (
  // Bus from the host.
  input wire logic [ADDR_W-1:0] flash_addr_i,
  input wire logic [DATA_W-1:0] flash_dq_i,
  input wire logic flash_ce_b_i,
  input wire logic flash_oe_b_i,
  input wire logic flash_we_b_i,
  input wire logic flash_rp_b_i,
  input wire logic flash_wp_i,
  // Answers to the host.
  output logic [DATA_W-1:0] flash_dq_o,
  output logic ready_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [3:0] lock = 4'h0;
  logic [7:0] pend = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [1:0] rb_mode = 2'h0;
  // Raised by the bench to stand for a programming supply below its lockout level.
  logic vpp_low = 1'b0;
  logic busy = 1'b0, susp = 1'b0, err = 1'b0, wlow = 1'b0;
  logic [7:0] sr_lat = 8'h00;
  logic [15:0] val, last = 16'h0000;
  int left = 0;
  wire sel = !flash_ce_b_i && !flash_oe_b_i && flash_rp_b_i;
  initial for (int i = 0; i < 64; i++) mem[i] = 16'h5A00 | 16'(i);
  ////////////////////////////////////////////////////////////////////////////
  task automatic go();
    busy = 1'b1;
    left = BUSY_NS;
  endtask
  task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (pend != 8'h00) begin
      if (vpp_low && pend != 8'hB8) err = 1'b1;
      else if (pend == 8'h40 || pend == 8'h10) begin
        if (lock[a[5:4]] && !flash_wp_i) err = 1'b1;
        else mem[a[5:0]] = d;
        go();
      end else if (pend == 8'h20 || pend == 8'h30) begin
        for (int i = 0; i < 64; i++)
          if (c == 8'hD0 && (pend == 8'h30 || i[5:4] == a[5:4])) mem[i] = 16'hFFFF;
        go();
      end else if (pend == 8'h60) begin
        if (c == 8'h01) lock[a[5:4]] = 1'b1;
        else if (flash_wp_i) lock = 4'h0;
        else err = 1'b1;
        go();
      end else rb_mode = c[1:0];
      pend = 8'h00;
    end else case (c)
      8'hFF: if (!busy || susp) mode = 2'h0;
      8'h90: mode = 2'h1;
      8'h98: mode = 2'h2;
      8'h70: mode = 2'h3;
      8'h50: if (!busy && !susp) err = 1'b0;
      8'hB0: susp = busy;
      8'hD0: susp = 1'b0;
      8'h40, 8'h10, 8'h20, 8'h30, 8'h60, 8'hB8: begin
        pend = c;
        mode = 2'h3;
      end
      default: ;
    endcase
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Both strobes may rise together, so one rise ends the cycle once only.
  always @(flash_ce_b_i or flash_we_b_i) begin
    if (!flash_ce_b_i && !flash_we_b_i && flash_rp_b_i) wlow = 1'b1;
    else if (wlow) begin
      wlow = 1'b0;
      take(flash_addr_i, flash_dq_i);
    end
  end
  always @(negedge flash_rp_b_i) begin
    mode = 2'h0;
    pend = 8'h00;
  end
  always @(posedge busy) begin
    while (left > 0) begin
      #10;
      if (!susp) left -= 10;
    end
    busy = 1'b0;
  end
  always @(posedge sel) sr_lat = {!busy || susp, susp, err, 5'h00};
  always @(negedge sel) last = val;
  always_comb begin
    case (mode)
      2'h0: val = mem[flash_addr_i[5:0]];
      2'h1: val = (flash_addr_i[1:0] == 2'h0) ? MFR_CODE :
                  (flash_addr_i[1:0] == 2'h1) ? DEV_CODE : {15'h0000, lock[flash_addr_i[5:4]]};
      2'h2: val = (flash_addr_i[5:0] == 6'h10) ? 16'h0051 : 16'h0000;
      default: val = {8'h00, sr_lat};
    endcase
  end
  // A released bus shows the inverse of the last word so stale data cannot pass.
  assign flash_dq_o = sel ? val : ~last;
  assign ready_busy_o = !(rb_mode == 2'h0 && busy && !susp && flash_rp_b_i);
endmodule

// [verification/test_flash_command_decoder.sv]
// Self-checking bench for the flash command controller.
// Assumes the flash model beside it and register offsets from the package.
module test_flash_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, junk;
  logic [20:0] flash_addr_o;
  logic [15:0] flash_dq_o, mdl_dq, dq_w;
  logic flash_dq_oe_o, flash_ce_b_o, flash_oe_b_o, flash_we_b_o, flash_rp_b_o, flash_wp_o, rb;
  int mismatches = 0, check_count = 0, ce_falls = 0;
  assign dq_w = flash_dq_oe_o ? flash_dq_o : mdl_dq;
  fcd_host #(.ADDR_W(21), .DATA_W(16)) dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_w), .flash_ce_b_o(flash_ce_b_o),
    .flash_oe_b_o(flash_oe_b_o), .flash_we_b_o(flash_we_b_o), .flash_rp_b_o(flash_rp_b_o),
    .flash_wp_o(flash_wp_o), .ready_busy_output_i(rb));
  fcd_flash_model #(.ADDR_W(21), .DATA_W(16)) model_u (.flash_addr_i(flash_addr_o),
    .flash_dq_i(dq_w), .flash_ce_b_i(flash_ce_b_o), .flash_oe_b_i(flash_oe_b_o),
    .flash_we_b_i(flash_we_b_o), .flash_rp_b_i(flash_rp_b_o), .flash_wp_i(flash_wp_o),
    .flash_dq_o(mdl_dq), .ready_busy_o(rb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic cyc(input logic [20:0] a, input logic [15:0] d, input fcd_pkg::fcd_op_type op,
                     output logic [31:0] s);
    int n;
    wr(fcd_pkg::REG_ADDR, {11'h0, a});
    wr(fcd_pkg::REG_DATA, {16'h0, d});
    wr(fcd_pkg::REG_CMD, {28'h0, op});
    n = 0;
    do begin
      rd(fcd_pkg::REG_STATUS, s);
      n++;
    end while (s[1] !== 1'b1 && n < 50);
    chk("bus cycle done in time", 32'h1, {31'h0, s[1]});
  endtask
  task automatic fwr(input logic [20:0] a, input logic [15:0] d);
    cyc(a, d, fcd_pkg::OP_WRITE_CYCLE, junk);
  endtask
  task automatic frd(input logic [20:0] a, output logic [31:0] d);
    cyc(a, 16'h0, fcd_pkg::OP_READ_CYCLE, junk);
    rd(fcd_pkg::REG_RDATA, d);
  endtask
  // Polls the flash busy bit; seen tells whether busy was ever shown.
  task automatic wait_ready(output logic seen);
    logic [31:0] s;
    int n;
    seen = 1'b0;
    n = 0;
    do begin
      rd(fcd_pkg::REG_STATUS, s);
      seen |= s[4];
      n++;
    end while (s[4] !== 1'b0 && n < 100);
    chk("flash ready in time", 32'h0, {31'h0, s[4]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    logic [31:0] v, s;
    int c0;
    rd(fcd_pkg::REG_CTRL, v);
    chk("ctrl after reset", {22'h0, fcd_pkg::CMD_READ_ARRAY, 2'h0}, v);
    rd(4'hF, v);
    chk("unmapped read", 32'h0, v);
    c0 = ce_falls;
    cyc(21'h5, 16'h00FF, fcd_pkg::OP_WRITE_CYCLE, s);
    chk("write in powerdown", 32'h0E, {27'h0, s[4:0]});
    wr(fcd_pkg::REG_CTRL, 32'h3);
    cyc(21'h5, 16'h0077, fcd_pkg::OP_WRITE_CYCLE, s);
    chk("undefined code", 32'h0E, {27'h0, s[4:0]});
    rd(fcd_pkg::REG_ADDR, v);
    chk("address readback", 32'h5, v);
    rd(fcd_pkg::REG_DATA, v);
    chk("data readback", 32'h77, v);
    chk("no strobe when refused", 32'(c0), 32'(ce_falls));
    frd(21'h3, v);
    chk("array after powerup", 32'h5A03, v);
    $display("start test ended");
  endtask
  task automatic t_write();
    logic [7:0] codes [2];
    logic [31:0] v;
    logic seen;
    codes = '{8'h40, 8'h10};
    for (int i = 0; i < 2; i++) begin
      fwr(21'h5 + 21'(i), {8'h0, codes[i]});
      fwr(21'h5 + 21'(i), 16'hC3A0 + 16'(i));
      wait_ready(seen);
      chk("busy while writing", 32'h1, {31'h0, seen});
      fwr(21'h0, 16'h00FF);
      frd(21'h5 + 21'(i), v);
      chk("programmed word", 32'hC3A0 + 32'(i), v);
    end
    model_u.vpp_low = 1'b1;
    fwr(21'h5, 16'h0040);
    fwr(21'h5, 16'h1234);
    model_u.vpp_low = 1'b0;
    fwr(21'h0, 16'h0070);
    frd(21'h0, v);
    chk("error after refused write", 32'hA0, v);
    fwr(21'h0, 16'h0050);
    frd(21'h0, v);
    chk("error cleared", 32'h80, v);
    fwr(21'h0, 16'h00FF);
    frd(21'h5, v);
    chk("word kept at low supply", 32'hC3A0, v);
    $display("write test ended");
  endtask
  task automatic t_modes();
    logic [31:0] v;
    fwr(21'h0, 16'h0070);
    frd(21'h123, v);
    chk("status read", 32'h80, v);
    fwr(21'h0, 16'h0090);
    frd(21'h0, v);
    chk("maker code", 32'h00A1, v);
    frd(21'h1, v);
    chk("device code", 32'h00B2, v);
    fwr(21'h0, 16'h0098);
    frd(21'h10, v);
    chk("query value", 32'h0051, v);
    rd(fcd_pkg::REG_CTRL, v);
    chk("last code", {22'h0, 8'h98, 2'h3}, v);
    fwr(21'h0, 16'h00B8);
    fwr(21'h0, 16'h0001);
    rd(fcd_pkg::REG_STATUS, v);
    chk("pulse mode chosen", 32'h0, {31'h0, v[3]});
    fwr(21'h0, 16'h00B8);
    fwr(21'h0, 16'h0000);
    rd(fcd_pkg::REG_STATUS, v);
    chk("level mode chosen", 32'h1, {31'h0, v[3]});
    fwr(21'h40, 16'h00E8);
    cyc(21'h40, 16'h0000, fcd_pkg::OP_WRITE_CYCLE, v);
    cyc(21'h40, 16'h1111, fcd_pkg::OP_WRITE_CYCLE, v);
    chk("multi payload taken", 32'h0, {31'h0, v[2]});
    rd(fcd_pkg::REG_CTRL, v);
    chk("multi still open", {22'h0, 8'hE8, 2'h3}, v);
    fwr(21'h0, 16'h00D0);
    rd(fcd_pkg::REG_CTRL, v);
    chk("multi closed", {22'h0, 8'hD0, 2'h3}, v);
    $display("mode test ended");
  endtask
  task automatic t_erase();
    logic [31:0] v;
    logic seen;
    fwr(21'h15, 16'h0020);
    fwr(21'h15, 16'h00D0);
    fwr(21'h0, 16'h00B0);
    rd(fcd_pkg::REG_STATUS, v);
    chk("line free when suspended", 32'h0, {31'h0, v[4]});
    fwr(21'h0, 16'h00D0);
    fwr(21'h0, 16'h00FF);
    wait_ready(seen);
    chk("busy after resume", 32'h1, {31'h0, seen});
    frd(21'h15, v);
    chk("array refused while busy", 32'h80, v);
    fwr(21'h0, 16'h00FF);
    frd(21'h15, v);
    chk("erased word", 32'hFFFF, v);
    frd(21'h5, v);
    chk("other block kept", 32'hC3A0, v);
    $display("erase test ended");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge flash_ce_b_o) ce_falls++;
  always @(negedge ref_clk_i) if (flash_oe_b_o === 1'b0 && flash_we_b_o === 1'b0) chk("oe and we", 32'h0, 32'h1);
  initial forever #25 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_start();
    t_write();
    t_modes();
    t_erase();
    close_out();
  end
  // About 1000 cycles are needed; the watchdog leaves a wide margin.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    close_out();
  end
endmodule
